// ==== logic/stepper_sync_alarm_gate_config.sv ====
// config bank: microstep mode, sync pin, fault mask and gate drive timing
//
// How it works
// - microstep_config write while running is dropped and raises command error.
// - with sync disabled, busy/sync pin goes low during command execution.
// - with sync enabled, pin shows electrical position bit 7 minus select code.
// - each fault mask bit lets its alarm pull the fault pin low.
// - mask bits: overcurrent, shutdown, warning, uvlo, adc uvlo, stall, switch, cmd error.
// - timing a holds clock monitor 11, boost 10:8, current 7:5, cc 4:0.
// - gate current code maps to 4,4,8,16,24,32,64,96 mA.
// - constant-current time is (code+1)*125 ns, capped at 3750 ns.
// - boost time 0, clock-dependent step, then 125..1000 ns.
// - clock monitor bit turns system clock supervision on or off.
// - timing b holds blanking 7:5 and dead time 4:0.
// - dead time is (code+1)*125 ns between opposite gates.
// - comparators masked (code+1)*125 ns after every commutation.
// - step code 0 full, 1 half, then 1/4 up to 1/128.
// - a change of step resolution resets electrical position to first microstep.
module stepper_sync_alarm_gate_config (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [1:0] reg_sel,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic motor_running,
    input wire logic cmd_executing,
    input wire logic [7:0] electrical_position,
    input wire logic [7:0] alarm_active,
    input wire logic cmd_error_clear,
    input wire logic [1:0] osc_freq_code,
    input wire logic commutation,
    output logic cmd_error,
    output logic busy_sync,
    output logic fault_out,
    output logic fault_oe_n,
    output logic electrical_position_reset,
    output logic [2:0] step_resolution,
    output logic [6:0] gate_current_ma,
    output logic [stepper_cfg_pkg::CNT_W-1:0] constant_current_cycles,
    output logic [stepper_cfg_pkg::CNT_W-1:0] turnoff_boost_cycles,
    output logic [stepper_cfg_pkg::CNT_W-1:0] dead_time_cycles,
    output logic clock_monitor_enable,
    output logic comparator_blank
);
    import stepper_cfg_pkg::*;

    // ps to cycles, least time so round up
    function automatic logic [CNT_W-1:0] ps_to_cycles(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return c[CNT_W-1:0];
    endfunction

    // (code+1) steps of 125 ns as cycles
    function automatic logic [CNT_W-1:0] steps_to_cycles(input logic [4:0] code);
        return ps_to_cycles((int'(code) + 1) * STEP_PS);
    endfunction

    logic [7:0] microstep_config_reg, microstep_config_next;
    logic [7:0] fault_pin_mask_reg, fault_pin_mask_next;
    logic [15:0] gate_drive_timing_a_reg, gate_drive_timing_a_next;
    logic [7:0] gate_drive_timing_b_reg, gate_drive_timing_b_next;
    logic cmd_error_reg, cmd_error_next;
    logic el_reset_reg, el_reset_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [2:0] new_step_sel;

    // register writes and the command error flag
    always_comb begin
        microstep_config_next = microstep_config_reg;
        fault_pin_mask_next = fault_pin_mask_reg;
        gate_drive_timing_a_next = gate_drive_timing_a_reg;
        gate_drive_timing_b_next = gate_drive_timing_b_reg;
        el_reset_next = 1'b0;
        new_step_sel = reg_wdata[STEP_SEL_LSB +: 3];
        // clear first so a same-cycle set wins
        cmd_error_next = cmd_error_reg & ~cmd_error_clear;
        if (reg_wr) begin
            unique case (reg_sel)
                SEL_MICROSTEP: begin
                    if (motor_running) begin
                        cmd_error_next = 1'b1;
                    end else begin
                        // bit 3 is kept zero whatever the host sends
                        microstep_config_next = reg_wdata[7:0] & MICROSTEP_WMASK;
                        // a new resolution invalidates the waveform phase
                        el_reset_next = new_step_sel !=
                            microstep_config_reg[STEP_SEL_LSB +: 3];
                    end
                end
                SEL_FAULT_MASK: fault_pin_mask_next = reg_wdata[7:0];
                SEL_GATE_A: gate_drive_timing_a_next = reg_wdata & GATE_A_WMASK;
                SEL_GATE_B: gate_drive_timing_b_next = reg_wdata[7:0];
            endcase
        end
        // read data, captured on the read strobe
        rdata_next = rdata_reg;
        if (reg_rd) begin
            unique case (reg_sel)
                SEL_MICROSTEP: rdata_next = {8'h00, microstep_config_reg};
                SEL_FAULT_MASK: rdata_next = {8'h00, fault_pin_mask_reg};
                SEL_GATE_A: rdata_next = gate_drive_timing_a_reg;
                SEL_GATE_B: rdata_next = {8'h00, gate_drive_timing_b_reg};
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            microstep_config_reg <= MICROSTEP_RST;
            fault_pin_mask_reg <= FAULT_MASK_RST;
            gate_drive_timing_a_reg <= GATE_A_RST;
            gate_drive_timing_b_reg <= GATE_B_RST;
            cmd_error_reg <= 1'b0;
            el_reset_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            microstep_config_reg <= microstep_config_next;
            fault_pin_mask_reg <= fault_pin_mask_next;
            gate_drive_timing_a_reg <= gate_drive_timing_a_next;
            gate_drive_timing_b_reg <= gate_drive_timing_b_next;
            cmd_error_reg <= cmd_error_next;
            el_reset_reg <= el_reset_next;
            rdata_reg <= rdata_next;
        end
    end

    logic busy_sync_reg, busy_sync_next;
    logic fault_oe_n_reg, fault_oe_n_next;
    logic [6:0] gate_current_select_reg, gate_current_select_next;
    logic [CNT_W-1:0] cc_reg, cc_next, boost_reg, boost_next, dead_reg, dead_next;
    logic [CNT_W-1:0] blank_cnt_reg, blank_cnt_next;
    logic blank_reg, blank_next;
    logic [7:0] alarms;
    logic [2:0] sync_sel;
    logic [4:0] cc_code;

    // pin drive and decoded timing
    always_comb begin
        sync_sel = microstep_config_reg[SYNC_SEL_LSB +: 3];
        // sync mode: code 0 picks position bit 7, code 7 picks bit 0
        if (microstep_config_reg[SYNC_EN_BIT]) begin
            busy_sync_next = electrical_position[3'h7 - sync_sel];
        end else begin
            busy_sync_next = ~cmd_executing;
        end
        // own command error joins the external alarm in bit 7
        alarms = alarm_active;
        alarms[ALM_CMD_ERROR] = alarm_active[ALM_CMD_ERROR] | cmd_error_reg;
        fault_oe_n_next = ~|(alarms & fault_pin_mask_reg);
        unique case (gate_drive_timing_a_reg[GATE_CURRENT_SELECT_LSB +: 3])
            3'h0, 3'h1: gate_current_select_next = 7'h04;
            3'h2: gate_current_select_next = 7'h08;
            3'h3: gate_current_select_next = 7'h10;
            3'h4: gate_current_select_next = 7'h18;
            3'h5: gate_current_select_next = 7'h20;
            3'h6: gate_current_select_next = 7'h40;
            3'h7: gate_current_select_next = 7'h60;
        endcase
        cc_code = gate_drive_timing_a_reg[CC_LSB +: 5];
        if (cc_code > 5'(CC_MAX_CODE)) begin
            cc_code = 5'(CC_MAX_CODE);
        end
        cc_next = steps_to_cycles(cc_code);
        unique case (gate_drive_timing_a_reg[BOOST_LSB +: 3])
            3'h0: boost_next = '0;
            3'h1: begin
                unique case (osc_freq_code)
                    2'h0: boost_next = ps_to_cycles(BOOST_STEP_8_PS);
                    2'h2: boost_next = ps_to_cycles(BOOST_STEP_24_PS);
                    default: boost_next = ps_to_cycles(BOOST_STEP_16_PS);
                endcase
            end
            3'h2: boost_next = steps_to_cycles(5'h00);
            3'h3: boost_next = steps_to_cycles(5'h01);
            3'h4: boost_next = steps_to_cycles(5'h02);
            3'h5: boost_next = steps_to_cycles(5'h03);
            3'h6: boost_next = steps_to_cycles(5'h05);
            3'h7: boost_next = steps_to_cycles(5'h07);
        endcase
        dead_next = steps_to_cycles(gate_drive_timing_b_reg[DEAD_LSB +: 5]);
        // blanking restarts on each commutation, then counts down
        if (commutation) begin
            blank_cnt_next = steps_to_cycles({2'b00, gate_drive_timing_b_reg[BLANK_LSB +: 3]});
        end else if (blank_cnt_reg != '0) begin
            blank_cnt_next = blank_cnt_reg - 1'b1;
        end else begin
            blank_cnt_next = '0;
        end
        // flag registered from the next count so the pin leaves a flop with no extra lag
        blank_next = blank_cnt_next != '0;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            busy_sync_reg <= 1'b1;
            fault_oe_n_reg <= 1'b1;
            gate_current_select_reg <= 7'h04;
            cc_reg <= '0;
            boost_reg <= '0;
            dead_reg <= '0;
            blank_cnt_reg <= '0;
            blank_reg <= 1'b0;
        end else begin
            busy_sync_reg <= busy_sync_next;
            fault_oe_n_reg <= fault_oe_n_next;
            gate_current_select_reg <= gate_current_select_next;
            cc_reg <= cc_next;
            boost_reg <= boost_next;
            dead_reg <= dead_next;
            blank_cnt_reg <= blank_cnt_next;
            blank_reg <= blank_next;
        end
    end

    // outputs straight from flops; fault pin only ever pulls low
    assign reg_rdata = rdata_reg;
    assign cmd_error = cmd_error_reg;
    assign busy_sync = busy_sync_reg;
    assign fault_out = 1'b0 & fault_oe_n_reg;
    assign fault_oe_n = fault_oe_n_reg;
    assign electrical_position_reset = el_reset_reg;
    assign step_resolution = microstep_config_reg[STEP_SEL_LSB +: 3];
    assign gate_current_ma = gate_current_select_reg;
    assign constant_current_cycles = cc_reg;
    assign turnoff_boost_cycles = boost_reg;
    assign dead_time_cycles = dead_reg;
    assign clock_monitor_enable = gate_drive_timing_a_reg[CLK_MON_BIT];
    assign comparator_blank = blank_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_running_cfg_write;
        reg_wr && reg_sel == SEL_MICROSTEP && motor_running;
    endsequence
    property p_running_write_dropped;
        s_running_cfg_write |=> $stable(microstep_config_reg) && cmd_error;
    endproperty
    a_running_write_dropped: assert property (p_running_write_dropped)
        else $error("running write taken");
    property p_busy_low;
        !microstep_config_reg[SYNC_EN_BIT] && cmd_executing |=> !busy_sync;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy pin not low");
    property p_sync_bit;
        microstep_config_reg[SYNC_EN_BIT] && sync_sel == 3'h0
            |=> busy_sync == $past(electrical_position[7]);
    endproperty
    a_sync_bit: assert property (p_sync_bit) else $error("sync bit wrong");
    property p_fault_pull;
        |(alarm_active & fault_pin_mask_reg) |=> !fault_oe_n;
    endproperty
    a_fault_pull: assert property (p_fault_pull) else $error("fault not driven");
    property p_cmd_err_alarm;
        cmd_error && fault_pin_mask_reg[ALM_CMD_ERROR] |=> !fault_oe_n;
    endproperty
    a_cmd_err_alarm: assert property (p_cmd_err_alarm) else $error("cmd error alarm lost");
    property p_gate_current_select_max;
        gate_drive_timing_a_reg[GATE_CURRENT_SELECT_LSB +: 3] == 3'h7 |=> gate_current_ma == 7'h60;
    endproperty
    a_gate_current_select_max: assert property (p_gate_current_select_max) else $error("gate current wrong");
    property p_cc_cap;
        gate_drive_timing_a_reg[CC_LSB +: 5] == 5'h1f |=> constant_current_cycles == 10'd469;
    endproperty
    a_cc_cap: assert property (p_cc_cap) else $error("cc cap wrong");
    property p_dead_max;
        gate_drive_timing_b_reg[DEAD_LSB +: 5] == 5'h1f |=> dead_time_cycles == 10'd500;
    endproperty
    a_dead_max: assert property (p_dead_max) else $error("dead time wrong");
    sequence s_blank_min;
        commutation && gate_drive_timing_b_reg[BLANK_LSB +: 3] == 3'h0;
    endsequence
    property p_blank_len;
        s_blank_min ##1 !commutation [*8] |-> comparator_blank;
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("blanking too short");
    property p_el_reset;
        reg_wr && reg_sel == SEL_MICROSTEP && !motor_running
            && reg_wdata[2:0] != step_resolution |=> electrical_position_reset;
    endproperty
    a_el_reset: assert property (p_el_reset) else $error("position reset missing");
endmodule

// ==== logic/stepper_cfg_pkg.sv ====
// package: register ids, field layouts, reset values and timing constants of the config bank
package stepper_cfg_pkg;
    // register select codes on the register port
    localparam logic [1:0] SEL_MICROSTEP = 2'h0;
    localparam logic [1:0] SEL_FAULT_MASK = 2'h1;
    localparam logic [1:0] SEL_GATE_A = 2'h2;
    localparam logic [1:0] SEL_GATE_B = 2'h3;
    // microstep_config fields
    localparam int SYNC_EN_BIT = 7;
    localparam int SYNC_SEL_LSB = 4;
    localparam int ZERO_BIT = 3;
    localparam int STEP_SEL_LSB = 0;
    localparam logic [7:0] MICROSTEP_WMASK = 8'hf7;
    // alarm positions in the mask
    localparam int ALM_OVERCURRENT = 0;
    localparam int ALM_CMD_ERROR = 7;
    // gate_drive_timing_a fields
    localparam int CLK_MON_BIT = 11;
    localparam int BOOST_LSB = 8;
    localparam int GATE_CURRENT_SELECT_LSB = 5;
    localparam int CC_LSB = 0;
    localparam logic [15:0] GATE_A_WMASK = 16'h0fff;
    // gate_drive_timing_b fields
    localparam int BLANK_LSB = 5;
    localparam int DEAD_LSB = 0;
    // reset values
    localparam logic [7:0] MICROSTEP_RST = 8'h00;
    localparam logic [7:0] FAULT_MASK_RST = 8'h00;
    localparam logic [15:0] GATE_A_RST = 16'h0000;
    localparam logic [7:0] GATE_B_RST = 8'h00;
    // timing: one time step and the system clock period, both in ps
    localparam int STEP_PS = 125000;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CC_MAX_CODE = 29;
    // step cycles: least time, rounded up
    localparam int STEP_CYCLES = (STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // boost code 001 step per oscillator code (8, 16, 24, 32 MHz), in ps
    localparam int BOOST_STEP_8_PS = 125000;
    localparam int BOOST_STEP_16_PS = 62500;
    localparam int BOOST_STEP_24_PS = 83300;
    localparam int CNT_W = 10;
endpackage

// ==== bench/motion_side_model.sv ====
// partner model: motion engine position source and host position bookkeeping
module motion_side_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic electrical_position_reset,
    input wire logic pos_load,
    input wire logic [7:0] pos_target,
    output logic [7:0] electrical_position,
    output logic [15:0] pos_reset_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [21:0] absolute_position;
    // the device's reset pulse wins over a load, so a mode change always lands on step one
    always @(posedge sys_clk) begin
        if (!resetn) begin
            electrical_position <= 8'h00;
            pos_reset_count <= 16'h0000;
            absolute_position <= 22'h000000;
        end else if (electrical_position_reset) begin
            electrical_position <= 8'h00;
            pos_reset_count <= pos_reset_count + 16'h0001;
            absolute_position <= 22'h000000; // stale after a mode change, so cleared
        end else if (pos_load) begin
            electrical_position <= pos_target;
            absolute_position <= absolute_position + 22'h000001;
        end
    end
endmodule

// ==== bench/stepper_sync_alarm_gate_config_tb.sv ====
// self-checking testbench for the stepper config bank
module stepper_sync_alarm_gate_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import stepper_cfg_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0] reg_sel = 2'h0, osc_freq_code = 2'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, pos_reset_count;
    logic motor_running = 1'b0, cmd_executing = 1'b0, cmd_error_clear = 1'b0;
    logic commutation = 1'b0, pos_load = 1'b0;
    logic [7:0] alarm_active = 8'h00, pos_target = 8'h00, electrical_position;
    logic cmd_error, busy_sync, fault_out, fault_oe_n, electrical_position_reset;
    logic clock_monitor_enable, comparator_blank;
    logic [2:0] step_resolution;
    logic [6:0] gate_current_ma;
    logic [CNT_W-1:0] constant_current_cycles, turnoff_boost_cycles, dead_time_cycles;
    int bad_count = 0, samples_checked = 0, n, d;
    int gate_current_select_ma [8] = '{4, 4, 8, 16, 24, 32, 64, 96};
    int boost_cyc [8] = '{0, 0, 16, 32, 47, 63, 94, 125};
    int step1_cyc [4] = '{16, 8, 11, 8};

    stepper_sync_alarm_gate_config dut_u (.sys_clk, .resetn, .reg_sel, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .motor_running, .cmd_executing, .electrical_position,
        .alarm_active, .cmd_error_clear, .osc_freq_code, .commutation, .cmd_error, .busy_sync,
        .fault_out, .fault_oe_n, .electrical_position_reset, .step_resolution,
        .gate_current_ma, .constant_current_cycles, .turnoff_boost_cycles, .dead_time_cycles,
        .clock_monitor_enable, .comparator_blank);
    motion_side_model model_u (.sys_clk, .resetn, .electrical_position_reset, .pos_load,
        .pos_target, .electrical_position, .pos_reset_count);

    always #4 sys_clk = ~sys_clk;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // least time that covers ns, in 8 ns clock cycles
    function automatic int ns_cyc(input int ns);
        return (ns + 7) / 8;
    endfunction
    // let edges pass, then sample once registered outputs have settled
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // decoded outputs trail the register by one edge, hence the extra wait
    task automatic wr(input logic [1:0] sel, input logic [15:0] data);
        @(posedge sys_clk);
        reg_sel <= sel;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        tick(2);
    endtask
    task automatic rd_chk(input logic [1:0] sel, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_sel <= sel;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask
    task automatic setpos(input logic [7:0] v);
        @(posedge sys_clk);
        pos_target <= v;
        pos_load <= 1'b1;
        @(posedge sys_clk);
        pos_load <= 1'b0;
        tick(2);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // watchdog: the sequence needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        tick(2);
        chk("gate_current_ma", 16'd4, 16'(gate_current_ma));
        chk("fault_oe_n", 16'h1, 16'(fault_oe_n));
        for (int s = 0; s < 4; s++) rd_chk(s[1:0], 16'h0000);
        wr(SEL_MICROSTEP, 16'h00f5);
        rd_chk(SEL_MICROSTEP, 16'h00f5);
        chk("step_resolution", 16'h5, 16'(step_resolution));
        chk("pos_reset_count", 16'h1, pos_reset_count);
        wr(SEL_MICROSTEP, 16'h00f5);
        chk("pos_reset_count", 16'h1, pos_reset_count);
        // walk every sync select code with the chosen bit high, then low
        for (int c = 0; c < 8; c++) begin
            wr(SEL_MICROSTEP, {8'h00, 1'b1, c[2:0], 4'h5});
            setpos(8'(1 << (7 - c)));
            chk("busy_sync", 16'h1, 16'(busy_sync));
            setpos(~8'(1 << (7 - c)));
            chk("busy_sync", 16'h0, 16'(busy_sync));
        end
        wr(SEL_MICROSTEP, 16'h0005);
        @(posedge sys_clk);
        cmd_executing <= 1'b1;
        tick(2);
        chk("busy_sync", 16'h0, 16'(busy_sync));
        @(posedge sys_clk);
        cmd_executing <= 1'b0;
        tick(2);
        chk("busy_sync", 16'h1, 16'(busy_sync));
        // one mask bit at a time: its own alarm pulls low, all the others are ignored
        for (int i = 0; i < 8; i++) begin
            wr(SEL_FAULT_MASK, 16'(1 << i));
            @(posedge sys_clk);
            alarm_active <= 8'(1 << i);
            tick(2);
            chk("fault_oe_n", 16'h0, 16'(fault_oe_n));
            @(posedge sys_clk);
            alarm_active <= ~8'(1 << i);
            tick(2);
            chk("fault_oe_n", 16'h1, 16'(fault_oe_n));
            chk("fault_out", 16'h0, 16'(fault_out));
        end
        @(posedge sys_clk);
        alarm_active <= 8'h00;
        motor_running <= 1'b1;
        wr(SEL_MICROSTEP, 16'h0003);
        rd_chk(SEL_MICROSTEP, 16'h0005);
        chk("cmd_error", 16'h1, 16'(cmd_error));
        chk("fault_oe_n", 16'h0, 16'(fault_oe_n));
        @(posedge sys_clk);
        motor_running <= 1'b0;
        cmd_error_clear <= 1'b1;
        @(posedge sys_clk);
        cmd_error_clear <= 1'b0;
        tick(2);
        chk("cmd_error", 16'h0, 16'(cmd_error));
        for (int c = 0; c < 8; c++) begin
            d = 31 - c;
            n = (c % 2) * 2048 + c * 256 + c * 32 + d;
            wr(SEL_GATE_A, 16'hf000 | 16'(n));
            rd_chk(SEL_GATE_A, 16'(n));
            chk("gate_current_ma", 16'(gate_current_select_ma[c]), 16'(gate_current_ma));
            // codes above 29 saturate at 3750 ns
            n = ns_cyc(((d > 29 ? 29 : d) + 1) * 125);
            chk("constant_current_cycles", 16'(n), 16'(constant_current_cycles));
            chk("clock_monitor_enable", 16'(c % 2), 16'(clock_monitor_enable));
            if (c > 1) begin
                chk("turnoff_boost_cycles", 16'(boost_cyc[c]), 16'(turnoff_boost_cycles));
            end
        end
        for (int o = 0; o < 4; o++) begin
            @(posedge sys_clk);
            osc_freq_code <= o[1:0];
            wr(SEL_GATE_A, 16'h0100);
            chk("turnoff_boost_cycles", 16'(step1_cyc[o]), 16'(turnoff_boost_cycles));
        end
        wr(SEL_GATE_A, 16'h0000);
        chk("turnoff_boost_cycles", 16'h0, 16'(turnoff_boost_cycles));
        // blanking length is counted from the comparator_blank level after each commutation
        for (int c = 0; c < 8; c++) begin
            d = (c * 9) % 32;
            wr(SEL_GATE_B, 16'(c << 5) | 16'(d));
            rd_chk(SEL_GATE_B, 16'(c << 5) | 16'(d));
            chk("dead_time_cycles", 16'(ns_cyc((d + 1) * 125)), 16'(dead_time_cycles));
            @(posedge sys_clk);
            commutation <= 1'b1;
            @(posedge sys_clk);
            commutation <= 1'b0;
            n = 0;
            // first sample lands in the cycle right after the edge that takes commutation
            repeat (200) begin
                #1;
                if (comparator_blank === 1'b1) n++;
                @(posedge sys_clk);
            end
            chk("comparator_blank cycles", 16'(ns_cyc((c + 1) * 125)), 16'(n));
        end
        final_report();
    end
endmodule
